/* File: bench/host_link_model.sv */
// Host model that frames instruction exchanges on the serial link.
`timescale 1ns/10ps
module host_link_model (
  input  wire        clk_in,
  input  wire        dout_in,
  output reg         cs_n_out,
  output reg         sclk_out,
  output reg         din_out,
  output reg  [16:0] rx_out
);
  integer i;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    din_out  = 1'b0;
    rx_out   = 17'h00000;
  end
  task half;
    begin
      repeat (4) @(posedge clk_in);
      #1;
    end
  endtask
  // Sends n clocks; with hold set the select stays low for the next exchange.
  task xfer(input [7:0] ins, input [4:0] n, input hold);
    begin
      cs_n_out = 1'b0;
      half;
      for (i = 0; i < n; i = i + 1) begin
        din_out = (i < 8) ? ins[i] : ~din_out;
        half;
        sclk_out = 1'b1;
        half;
        rx_out = {rx_out[15:0], dout_in};
        sclk_out = 1'b0;
      end
      din_out = ~din_out;
      if (!hold) begin
        half;
        cs_n_out = 1'b1;
        half;
        half;
      end
    end
  endtask
endmodule // host_link_model

/* File: bench/serial_adc_chk.sv */
// Assertion checker for the serial converter instruction interface.
`timescale 1ns/10ps
module serial_adc_chk (
  input wire       clk_in,
  input wire       rst_n_in,
  input wire       chip_select_n_in,
  input wire       powerdown_pin_in,
  input wire       conv_n_in,
  input wire       serial_data_oe_out,
  input wire [3:0] mux_select_out,
  input wire       converter_enable_out,
  input wire       conversion_busy_out,
  input wire [7:0] analog_channel_pins_oe_out,
  input wire       test_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  test_pins_a: assert property (
    test_mode_out && $past(test_mode_out) |-> analog_channel_pins_oe_out == 8'hff)
    else $error("channel pins not outputs in test mode");
  user_pins_a: assert property (
    !test_mode_out && !$past(test_mode_out) |-> analog_channel_pins_oe_out == 8'h00)
    else $error("channel pins driven in user mode");
  hw_pd_a: assert property (
    powerdown_pin_in [*6] |-> !converter_enable_out)
    else $error("converter on while pin requests power down");
  abort_a: assert property (
    $fell(converter_enable_out) |-> ##[0:2] !conversion_busy_out)
    else $error("conversion survives power down");
  busy_pwr_a: assert property (
    $rose(conversion_busy_out) |-> converter_enable_out)
    else $error("conversion started while powered down");
  oe_sel_a: assert property (
    !chip_select_n_in [*6] |-> serial_data_oe_out)
    else $error("serial output idle while selected");
  oe_idle_a: assert property (
    chip_select_n_in [*6] |-> !serial_data_oe_out)
    else $error("serial output driven while deselected");
  read_only_a: assert property (
    $rose(conversion_busy_out) |-> !(conv_n_in && $past(conv_n_in, 8)))
    else $error("conversion started in read only exchange");
  mux_hold_a: assert property (
    conversion_busy_out && $past(conversion_busy_out) |-> $stable(mux_select_out))
    else $error("channel changed during conversion");
  conv_end_a: assert property (
    $rose(conversion_busy_out) |-> ##[1:200] !conversion_busy_out)
    else $error("conversion never ends");
endmodule // serial_adc_chk

bind serial_adc_instruction_interface serial_adc_chk serial_adc_chk_inst (
  .clk_in                     (clk_in),
  .rst_n_in                   (rst_n_in),
  .chip_select_n_in           (chip_select_n_in),
  .powerdown_pin_in           (powerdown_pin_in),
  .conv_n_in                  (conv_n_in),
  .serial_data_oe_out         (serial_data_oe_out),
  .mux_select_out             (mux_select_out),
  .converter_enable_out       (converter_enable_out),
  .conversion_busy_out        (conversion_busy_out),
  .analog_channel_pins_oe_out (analog_channel_pins_oe_out),
  .test_mode_out              (test_mode_out)
);

/* File: bench/tb_top.sv */
// Self-checking bench for the serial converter instruction interface.
`timescale 1ns/10ps
`include "serial_adc_defs.vh"
module tb_top;
  reg         clk_in, rst_n_in, powerdown_pin_in, conv_n_in, converter_input_two_greater_in;
  reg  [11:0] converter_magnitude_in;
  reg  [7:0]  seq [0:3];
  wire        chip_select_n_in, serial_clock_in, serial_instruction_in, serial_data_out;
  wire        serial_data_oe_out, mux_single_ended_out, converter_enable_out;
  wire        conversion_busy_out, end_of_conversion_n_out, test_mode_out;
  wire [16:0] rx;
  wire [3:0]  mux_select_out;
  wire [7:0]  analog_channel_pins_oe_out;
  wire [1:0]  acquisition_sel_out;
  integer     miscompares, n_compared, k, j;
  serial_adc_instruction_interface serial_adc_instruction_interface_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(chip_select_n_in),
    .serial_clock_in(serial_clock_in), .serial_instruction_in(serial_instruction_in),
    .powerdown_pin_in(powerdown_pin_in), .conv_n_in(conv_n_in),
    .converter_magnitude_in(converter_magnitude_in),
    .converter_input_two_greater_in(converter_input_two_greater_in),
    .serial_data_out(serial_data_out), .serial_data_oe_out(serial_data_oe_out),
    .mux_select_out(mux_select_out), .mux_single_ended_out(mux_single_ended_out),
    .converter_enable_out(converter_enable_out), .conversion_busy_out(conversion_busy_out),
    .end_of_conversion_n_out(end_of_conversion_n_out),
    .analog_channel_pins_oe_out(analog_channel_pins_oe_out),
    .acquisition_sel_out(acquisition_sel_out), .test_mode_out(test_mode_out));
  host_link_model host_link_model_inst (
    .clk_in(clk_in), .dout_in(serial_data_out), .cs_n_out(chip_select_n_in),
    .sclk_out(serial_clock_in), .din_out(serial_instruction_in), .rx_out(rx));
  task chk(input [16:0] seen, input [16:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task settle;
    begin
      repeat (12) @(posedge clk_in);
      #1;
    end
  endtask
  task ex(input [7:0] ins, input [4:0] n, input hold);
    begin
      host_link_model_inst.xfer(ins, n, hold);
      settle;
    end
  endtask
  task idle;
    begin
      for (k = 0; k < 400 && conversion_busy_out !== 1'b0; k = k + 1) begin
        @(posedge clk_in);
      end
      #1;
      if (k >= 400) miscompares = miscompares + 1;
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #2000000;
    miscompares = miscompares + 1;
    test_done;
  end
  initial begin
    miscompares = 0;
    n_compared = 0;
    rst_n_in = 1'b0;
    powerdown_pin_in = 1'b0;
    conv_n_in = 1'b0;
    converter_magnitude_in = 12'h5a3;
    converter_input_two_greater_in = 1'b1;
    seq[0] = `INS_RESET_A;
    seq[1] = `INS_RESET_B;
    seq[2] = `INS_RESET_C;
    seq[3] = `INS_USER_MODE;
    repeat (5) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    settle;
    chk(converter_enable_out, 17'h1);
    chk(acquisition_sel_out, `ACQ_DEFAULT);
    chk(test_mode_out, 17'h0);
    ex(8'h42, 5'd13, 1'b0);
    chk(mux_select_out, 17'h2);
    idle;
    converter_input_two_greater_in = 1'b0;
    ex(8'h43, 5'd13, 1'b0);
    chk(rx[12], 17'h1);
    idle;
    conv_n_in = 1'b1;
    ex(8'h44, 5'd13, 1'b0);
    chk(conversion_busy_out, 17'h0);
    chk(rx[12], 17'h0);
    conv_n_in = 1'b0;
    ex(8'h02, 5'd13, 1'b1);
    idle;
    ex(8'h05, 5'd9, 1'b1);
    chk(mux_select_out, 17'h5);
    idle;
    ex(8'h86, 5'd9, 1'b1);
    idle;
    ex(8'h47, 5'd17, 1'b0);
    chk(mux_select_out, 17'h7);
    idle;
    powerdown_pin_in = 1'b1;
    settle;
    chk(converter_enable_out, 17'h0);
    ex(`INS_POWER_UP, 5'd13, 1'b0);
    chk(converter_enable_out, 17'h0);
    powerdown_pin_in = 1'b0;
    settle;
    ex(`INS_POWER_DOWN, 5'd13, 1'b0);
    chk(converter_enable_out, 17'h0);
    powerdown_pin_in = 1'b1;
    settle;
    powerdown_pin_in = 1'b0;
    settle;
    chk(converter_enable_out, 17'h1);
    ex(`INS_POWER_DOWN, 5'd13, 1'b0);
    ex(`INS_POWER_UP, 5'd13, 1'b0);
    chk(converter_enable_out, 17'h1);
    host_link_model_inst.xfer(8'h42, 5'd13, 1'b0);
    powerdown_pin_in = 1'b1;
    settle;
    chk(conversion_busy_out, 17'h0);
    powerdown_pin_in = 1'b0;
    ex(`INS_TEST_MODE, 5'd13, 1'b0);
    chk(test_mode_out, 17'h1);
    chk(analog_channel_pins_oe_out, 17'hff);
    ex(`INS_STATUS, 5'd13, 1'b0);
    ex(`INS_STATUS, 5'd13, 1'b0);
    chk(rx[12:0], 17'h001d0);
    for (j = 0; j < 4; j = j + 1) begin
      ex(seq[j], 5'd13, 1'b0);
    end
    chk(test_mode_out, 17'h0);
    ex(`INS_POWER_UP, 5'd13, 1'b0);
    ex(8'h72, 5'd8, 1'b0);
    chk(acquisition_sel_out, 17'h2);
    chk(converter_enable_out, 17'h1);
    test_done;
  end
endmodule // tb_top

/* File: hw/serial_adc_defs.vh */
// Constants for the serial converter instruction interface.
`ifndef SERIAL_ADC_DEFS_VH
`define SERIAL_ADC_DEFS_VH
`define LEN_8_NOSIGN      5'h08
`define LEN_8_SIGN        5'h09
`define LEN_12_NOSIGN     5'h0c
`define LEN_12_SIGN       5'h0d
`define LEN_16_NOSIGN     5'h10
`define LEN_16_SIGN       5'h11
`define FMT_8             2'h0
`define FMT_12            2'h1
`define FMT_16            2'h2
`define ACQ_DEFAULT       2'h1
`define CONV_CYCLES       8'h28
`define ACQ_BASE          8'h04
`define ACQ_EXTRA         8'h01
`define INS_BITS          5'h08
`define INS_TEST_MODE     8'hf1
`define INS_TEST_MASK     8'hf1
`define INS_USER_MODE     8'hf0
`define INS_RESET_A       8'h70
`define INS_RESET_B       8'h50
`define INS_RESET_C       8'hd0
`define INS_POWER_UP      8'h50
`define INS_POWER_DOWN    8'hd0
`define INS_SIGN_MASK     8'hfe
`define INS_SIGN          8'hb0
`define INS_ACQ_MASK      8'hfc
`define INS_ACQ           8'h70
`define INS_STATUS        8'h30
`define INS_CONV_BIT      4
`define INS_SIGN_BIT      0
`define STAT_TEST_BIT     8
`endif

/* File: hw/serial_adc_instruction_interface.v */
// Device-side instruction decoder, mode state and conversion sequencing.
`timescale 1ns/10ps
`include "serial_adc_defs.vh"
module serial_adc_instruction_interface (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        chip_select_n_in,
  input  wire        serial_clock_in,
  input  wire        serial_instruction_in,
  input  wire        powerdown_pin_in,
  input  wire        conv_n_in,
  input  wire [11:0] converter_magnitude_in,
  input  wire        converter_input_two_greater_in,
  output reg         serial_data_out,
  output reg         serial_data_oe_out,
  output reg  [3:0]  mux_select_out,
  output reg         mux_single_ended_out,
  output reg         converter_enable_out,
  output reg         conversion_busy_out,
  output reg         end_of_conversion_n_out,
  output reg  [7:0]  analog_channel_pins_oe_out,
  output reg  [1:0]  acquisition_sel_out,
  output reg         test_mode_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ACQ  = 3'b010;
  localparam ST_CONV = 3'b100;

  reg  [2:0]  cs_sync_r;
  reg  [2:0]  sck_sync_r;
  reg  [1:0]  din_sync_r;
  reg  [1:0]  pd_sync_r;
  reg  [1:0]  conv_sync_r;
  reg         pd_prev_r;
  reg         sw_pd_r;
  reg         sign_on_r;
  reg         msb_first_r;
  reg  [1:0]  fmt_r;
  reg  [1:0]  pend_fmt_r;
  reg         pend_msb_r;
  reg         cur_sign_r;
  reg  [1:0]  cur_fmt_r;
  reg         cur_msb_r;
  reg         status_pend_r;
  reg         status_next_r;
  reg  [12:0] result_r;
  reg         result_valid_r;
  reg  [2:0]  state_r;
  reg  [7:0]  cnt_r;
  wire        cs_n;
  wire        frame_start;
  wire        sck_rise;
  wire        sck_fall;
  wire [7:0]  instr;
  wire        done;
  wire        dout;
  wire        powered_down;
  wire [4:0]  word_len;
  wire [8:0]  status_word;
  reg  [16:0] load_word;
  reg  [4:0]  rise_cnt_r;
  wire        cs_rise;
  wire        short_done;
  wire        decode;
  wire        read_only;

  function [4:0] len_of;
    input [1:0] fmt;
    input       sign;
    begin
      if (fmt == `FMT_8) begin
        len_of = sign ? `LEN_8_SIGN : `LEN_8_NOSIGN;
      end else if (fmt == `FMT_16) begin
        len_of = sign ? `LEN_16_SIGN : `LEN_16_NOSIGN;
      end else begin
        len_of = sign ? `LEN_12_SIGN : `LEN_12_NOSIGN;
      end
    end
  endfunction

  // Acquisition lasts 6, 10, 18 or 34 clocks for the four settings; the count
  // is loaded one short because the count of zero is a cycle of its own.
  function [7:0] acq_count;
    input [1:0] sel;
    begin
      acq_count = (`ACQ_BASE << sel) + `ACQ_EXTRA;
    end
  endfunction

  // Select, clock, data, power-down and conversion pins come from the host's
  // domain and pass two flip-flops before any logic reads them.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cs_sync_r   <= 3'b111;
      sck_sync_r  <= 3'b000;
      din_sync_r  <= 2'b00;
      pd_sync_r   <= 2'b00;
      conv_sync_r <= 2'b11;
    end else begin
      cs_sync_r   <= {cs_sync_r[1:0], chip_select_n_in};
      sck_sync_r  <= {sck_sync_r[1:0], serial_clock_in};
      din_sync_r  <= {din_sync_r[0], serial_instruction_in};
      pd_sync_r   <= {pd_sync_r[0], powerdown_pin_in};
      conv_sync_r <= {conv_sync_r[0], conv_n_in};
    end
  end

  // Counts rises within a strobed frame, so that a frame cut short after the
  // instruction bits still delivers its instruction when select goes high.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rise_cnt_r <= 5'h00;
    end else if (frame_start || done) begin
      rise_cnt_r <= 5'h00;
    end else if (sck_rise && rise_cnt_r < `INS_BITS) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end

  // Clock edges count only while select is low.
  assign cs_n         = cs_sync_r[1];
  assign frame_start  = cs_sync_r[2] & ~cs_sync_r[1];
  assign sck_rise     = ~cs_n & sck_sync_r[1] & ~sck_sync_r[2];
  assign sck_fall     = ~cs_n & ~sck_sync_r[1] & sck_sync_r[2];
  assign cs_rise      = cs_sync_r[1] & ~cs_sync_r[2];
  assign short_done   = cs_rise & (rise_cnt_r >= `INS_BITS);
  assign decode       = done | short_done;
  assign read_only    = conv_sync_r[1];
  assign powered_down = sw_pd_r | pd_sync_r[1];
  assign word_len     = len_of(cur_fmt_r, cur_sign_r);
  // Status from the top bit down: test mode, MSB first, sign, 16/17, 12/13,
  // 8/9, calibration busy (never here), power down, power up in progress.
  assign status_word  = {test_mode_out,
                         msb_first_r,
                         sign_on_r,
                         fmt_r == `FMT_16,
                         fmt_r == `FMT_12,
                         fmt_r == `FMT_8,
                         1'b0,
                         powered_down,
                         1'b0};

  // The word shifted out next: status if it was asked for, else the last result
  // in the current format; an aborted conversion leaves zeros.
  always @* begin
    load_word = 17'h00000;
    if (status_next_r) begin
      load_word[8:0] = status_word;
    end else if (!result_valid_r) begin
      load_word = 17'h00000;
    end else if (cur_fmt_r == `FMT_8) begin
      load_word[8:0] = {result_r[12], result_r[11:4]};
      if (!cur_sign_r) load_word[8] = 1'b0;
    end else if (cur_fmt_r == `FMT_16) begin
      load_word = {{5{result_r[12]}}, result_r[11:0]};
      if (!cur_sign_r) load_word[16] = 1'b0;
    end else begin
      load_word[12:0] = result_r;
      if (!cur_sign_r) load_word[12] = 1'b0;
    end
  end

  serial_adc_shifter shifter (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .frame_start_in (frame_start),
    .sclk_rise_in   (sck_rise),
    .sclk_fall_in   (sck_fall),
    .din_in         (din_sync_r[1]),
    .word_len_in    (word_len),
    .load_word_in   (load_word),
    .msb_first_in   (cur_msb_r),
    .instr_out      (instr),
    .done_out       (done),
    .dout_out       (dout)
  );

  // The data pin is driven only while the frame is selected.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      serial_data_out    <= 1'b0;
      serial_data_oe_out <= 1'b0;
    end else begin
      serial_data_out    <= dout;
      serial_data_oe_out <= ~cs_n;
    end
  end

  // Mode, power and conversion sequencing. An instruction acts once per exchange,
  // at the last counted clock or when a short strobed frame ends.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sw_pd_r        <= 1'b0;
      pd_prev_r      <= 1'b0;
      sign_on_r      <= 1'b1;
      msb_first_r    <= 1'b1;
      fmt_r          <= `FMT_12;
      pend_fmt_r     <= `FMT_12;
      pend_msb_r     <= 1'b1;
      cur_sign_r     <= 1'b1;
      cur_fmt_r      <= `FMT_12;
      cur_msb_r      <= 1'b1;
      status_pend_r  <= 1'b0;
      status_next_r  <= 1'b0;
      result_r       <= 13'h0000;
      result_valid_r <= 1'b1;
      state_r        <= ST_IDLE;
      cnt_r          <= 8'h00;
      mux_select_out <= 4'h0;
      mux_single_ended_out <= 1'b0;
      acquisition_sel_out  <= `ACQ_DEFAULT;
      test_mode_out  <= 1'b0;
    end else begin
      pd_prev_r <= pd_sync_r[1];
      // A software power down is lifted by the pin going high and then low.
      if (pd_prev_r && !pd_sync_r[1]) begin
        sw_pd_r <= 1'b0;
      end
      // A strobed select falling during a conversion cuts it short.
      if (frame_start) begin
        status_next_r <= status_pend_r;
        status_pend_r <= 1'b0;
        if (state_r != ST_IDLE) begin
          state_r        <= ST_IDLE;
          result_valid_r <= 1'b0;
        end
      end
      // Acquisition counts down, then the conversion; power down at any point
      // drops the conversion and marks the result invalid.
      case (state_r)
        ST_ACQ: begin
          if (powered_down) begin
            state_r <= ST_IDLE;
            result_valid_r <= 1'b0;
          end else if (cnt_r == 8'h00) begin
            state_r <= ST_CONV;
            cnt_r   <= `CONV_CYCLES;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_CONV: begin
          if (powered_down) begin
            state_r        <= ST_IDLE;
            result_valid_r <= 1'b0;
          end else if (cnt_r == 8'h00) begin
            state_r        <= ST_IDLE;
            result_valid_r <= 1'b1;
            result_r <= {converter_input_two_greater_in, converter_magnitude_in};
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      if (decode) begin
        cur_fmt_r     <= pend_fmt_r;
        cur_msb_r     <= pend_msb_r;
        cur_sign_r    <= sign_on_r;
        status_next_r <= 1'b0;
        if (test_mode_out) begin
          if (instr == `INS_USER_MODE) begin
            test_mode_out <= 1'b0;
          end else if (instr == `INS_STATUS) begin
            status_pend_r <= 1'b1;
            status_next_r <= 1'b1;
          end
        end else if ((instr & `INS_TEST_MASK) == `INS_TEST_MODE) begin
          test_mode_out <= 1'b1;
        end else if (!instr[`INS_CONV_BIT]) begin
          if (read_only) begin
          end else if (!powered_down) begin
            // The new format sets the length of the very next exchange.
            mux_select_out       <= instr[3:0];
            mux_single_ended_out <= instr[1];
            fmt_r       <= {instr[7], instr[6]};
            pend_fmt_r  <= {instr[7], instr[6]};
            cur_fmt_r   <= {instr[7], instr[6]};
            msb_first_r <= ~instr[5];
            pend_msb_r  <= ~instr[5];
            cur_msb_r   <= ~instr[5];
            state_r     <= ST_ACQ;
            cnt_r       <= acq_count(acquisition_sel_out);
          end
        end else if (instr == `INS_POWER_UP) begin
          sw_pd_r <= 1'b0;
        end else if (instr == `INS_POWER_DOWN) begin
          sw_pd_r <= 1'b1;
        end else if ((instr & `INS_SIGN_MASK) == `INS_SIGN) begin
          sign_on_r <= ~instr[`INS_SIGN_BIT];
          cur_sign_r <= ~instr[`INS_SIGN_BIT];
        end else if ((instr & `INS_ACQ_MASK) == `INS_ACQ) begin
          acquisition_sel_out <= instr[1:0];
        end else if (instr == `INS_STATUS) begin
          status_pend_r <= 1'b1;
          status_next_r <= 1'b1;
        end
      end
    end
  end

  // Pin-side status outputs follow the internal state one cycle later.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      converter_enable_out       <= 1'b1;
      conversion_busy_out        <= 1'b0;
      end_of_conversion_n_out    <= 1'b1;
      analog_channel_pins_oe_out <= 8'h00;
    end else begin
      converter_enable_out       <= ~powered_down;
      conversion_busy_out        <= (state_r != ST_IDLE);
      end_of_conversion_n_out    <= (state_r == ST_IDLE);
      analog_channel_pins_oe_out <= {8{test_mode_out}};
    end
  end
endmodule // serial_adc_instruction_interface

/* File: hw/serial_adc_shifter.v */
// Serial shift engine: bit counting, instruction capture and result output.
`timescale 1ns/10ps
module serial_adc_shifter (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        frame_start_in,
  input  wire        sclk_rise_in,
  input  wire        sclk_fall_in,
  input  wire        din_in,
  input  wire [4:0]  word_len_in,
  input  wire [16:0] load_word_in,
  input  wire        msb_first_in,
  output reg  [7:0]  instr_out,
  output reg         done_out,
  output reg         dout_out
);
  reg  [4:0]  bit_cnt_r;
  reg  [16:0] shift_r;
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (!rst_n_in) begin
      bit_cnt_r <= 5'h00;
      shift_r   <= 17'h00000;
      instr_out <= 8'h00;
      dout_out  <= 1'b0;
    end else if (frame_start_in) begin
      bit_cnt_r <= 5'h00;
      shift_r   <= load_word_in;
      dout_out  <= msb_first_in ? load_word_in[word_len_in - 5'h01] : load_word_in[0];
    end else if (sclk_rise_in) begin
      if (bit_cnt_r < 5'h08) begin
        instr_out[bit_cnt_r[2:0]] <= din_in;
      end
      if (bit_cnt_r == word_len_in - 5'h01) begin
        bit_cnt_r <= 5'h00;
        done_out  <= 1'b1;
        shift_r   <= load_word_in;
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end else if (sclk_fall_in && bit_cnt_r != 5'h00) begin
      dout_out <= msb_first_in ? shift_r[word_len_in - 5'h01 - bit_cnt_r]
                               : shift_r[bit_cnt_r];
    end else if (sclk_fall_in) begin
      shift_r  <= load_word_in;
      dout_out <= msb_first_in ? load_word_in[word_len_in - 5'h01] : load_word_in[0];
    end
  end
endmodule // serial_adc_shifter
